// ### verilog/acs_cfg.svh
// Purpose: named constants shared by both ends of the converter link
// Assumes: included by bare name from the package and the modules
// Notes: definitions only; the guard allows repeated inclusion
`ifndef ACS_CFG_SVH
`define ACS_CFG_SVH
// device register offsets (7-bit address space)
`define ACS_ADDR_CH0 7'h09
`define ACS_ADDR_CH1 7'h0E
`define ACS_ADDR_CH2 7'h13
`define ACS_ADDR_CH3 7'h18
`define ACS_ADDR_CRC 7'h3E
// channel configuration reset value and read mask (bits 5:3 read zero)
`define ACS_CFG_RST 16'h0000
`define ACS_CFG_RMASK 16'hFFC7
// input selector codes
`define ACS_MUX_NORM 2'h0
`define ACS_MUX_SHORT 2'h1
`define ACS_MUX_POS 2'h2
`define ACS_MUX_NEG 2'h3
// dc test levels and a shorted input result
`define ACS_TEST_POS 16'h2000
`define ACS_TEST_NEG 16'hE000
`define ACS_ZERO16 16'h0000
// register map checksum: polynomial and seed
`define ACS_CRC_POLY 16'h1021
`define ACS_CRC_INIT 16'hFFFF
// frame: six 16-bit words; the first two carry command and write data
`define ACS_FRAME_BITS 7'h60
`define ACS_CMD_BITS 7'h20
// command word fields
`define ACS_CMD_WR 15
`define ACS_CMD_AHI 14
`define ACS_CMD_ALO 8
// status word bits
`define ACS_ST_RESYNC 15
`define ACS_ST_FRESH 14
// external_clock_input periods per conversion, minus one
`define ACS_CONV_LAST 8'h0F
// divider half periods in system clocks, minus one
`define ACS_SCLK_LAST 4'h3
`define ACS_EXTERNAL_CLOCK_INPUT_LAST 4'h1
// host register addresses
`define ACS_H_CTRL 4'h0
`define ACS_H_CMD 4'h1
`define ACS_H_WDAT 4'h2
`define ACS_H_STAT 4'h3
`define ACS_H_RESP 4'h4
`define ACS_H_CH0 4'h5
`define ACS_H_CH1 4'h6
`define ACS_H_CH2 4'h7
`define ACS_H_CH3 4'h8
// lowest bit of the status word within a received frame
`define ACS_STAT_LSB 80
`define ACS_H_IST 4'h9
`define ACS_H_MASK 4'hA
`define ACS_H_PER 4'hB
// host control bits and interrupt bits
`define ACS_CTRL_START 0
`define ACS_CTRL_SYNC 1
`define ACS_IRQ_DONE 0
`define ACS_IRQ_RESYNC 1
`define ACS_IRQ_DATA_READY_PIN 2
`define ACS_IRQ_PERIOD 3
`endif

// ### verilog/acs_pkg.sv
// Purpose: state types of both link ends
// Assumes: acs_cfg.svh holds the numbers
// Notes: each module keeps all of its state in one packed struct
`default_nettype none
`include "acs_cfg.svh"
package acs_pkg;
	// device end state
	typedef struct packed {
		logic [3:0][15:0] cfg; // channel configuration words
		logic [15:0] crc; // register map checksum
		logic [3:0][15:0] res; // conversion result buffer
		logic [15:0] resp; // register read answer for next frame
		logic [95:0] out_sh; // outgoing frame shifter
		logic [31:0] in_sh; // command and write data
		logic [6:0] bits; // sclk rises seen in this frame
		logic [7:0] conv_cnt; // external_clock_input periods in conversion
		logic external_clock_input_q;
		logic sync_q;
		logic cs_q;
		logic sclk_q;
		logic read_done; // last result fully clocked out
		logic resync; // resynchronisation flag
		logic data_ready_pin_n;
		logic dout;
		logic dout_oe_n;
	} acs_dev_st_t;
	// host sequencer states
	typedef enum logic [1:0] {ACS_H_IDLE, ACS_H_XFER} acs_hstate_t;
	// host end state
	typedef struct packed {
		acs_hstate_t st;
		logic [15:0] cmd;
		logic [15:0] wdat;
		logic [15:0] rdata;
		logic [15:0] periods;
		logic [95:0] tx;
		logic [95:0] rx;
		logic [95:0] rx_hold;
		logic [6:0] bits;
		logic [3:0] div;
		logic [3:0] cdiv;
		logic [3:0] ist;
		logic [3:0] mask;
		logic [7:0] pcnt;
		logic external_clock_input;
		logic sync_n;
		logic cs_n;
		logic sclk;
		logic din;
		logic sync_req;
		logic data_ready_pin_q;
		logic irq;
	} acs_host_st_t;
endpackage : acs_pkg
`default_nettype wire

// ### verilog/acs_link_if.sv
// Purpose: serial link between converter and host controller
// Assumes: one system clock drives both ends
// Notes: the data-out line is resolved here from its enable
`timescale 1ns/1ns
`default_nettype none
interface acs_link_if;
	logic external_clock_input; // conversion clock from host
	logic sync_n; // sync/reset pin
	logic cs_n; // chip select
	logic sclk; // serial clock
	logic din; // host to device data
	logic dout; // device data out, valid when enabled
	logic dout_oe_n; // low while device drives dout
	logic data_ready_pin_n; // data ready
	logic dout_line; // resolved wire, driven low when released
	assign dout_line = dout_oe_n ? 1'b0 : dout;
	modport dev(input external_clock_input, input sync_n, input cs_n, input sclk,
		input din, output dout, output dout_oe_n, output data_ready_pin_n);
	modport host(output external_clock_input, output sync_n, output cs_n, output sclk,
		output din, input dout_line, input data_ready_pin_n);
endinterface : acs_link_if
`default_nettype wire

// ### verilog/acs_dev.sv
// Purpose: converter end: channel config, checksum, sync and frames
// Assumes: link inputs are synchronous to i_clk
// Notes: external_clock_input and sclk are sampled and edge detected, not clocks
//
// Operation
// [R1] selector picks pair, short, plus or minus test
// [R2] checksum register shows sixteen-bit map checksum
// [R3] misaligned sync sets resync flag again
// [R4] sync is an alignment check, host pulses aligned
// [R5] data read only after full frame; else repeated
// [R6] host clocks out every word of each frame
// [R7] host may count external_clock_input periods for timing
// [R8] host uses sync or data ready to stay aligned
// [R9] tied chip select needs both data checksums
// [R10] data out released while chip select high
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ns
`default_nettype none
`include "acs_cfg.svh"
module acs_dev import acs_pkg::*; (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic [3:0][15:0] i_ain, // digitised pair per channel
	output logic [3:0][1:0] o_chan_sel, // selector per channel
	output logic o_resync_flag,
	acs_link_if.dev lnk
);
	acs_dev_st_t s_r; // registered state
	acs_dev_st_t s_nxt; // next state
	logic clk_rise; // external_clock_input rising seen this cycle
	logic sync_fall; // sync pin falling seen this cycle
	logic cs_fall;
	logic cs_rise;
	logic sclk_rise;
	logic sclk_fall;
	logic conv; // a conversion period ends
	logic [15:0] cmd; // received command word
	logic [15:0] wdat; // received write data
	logic [6:0] addr; // command address
	logic [2:0] chan_hit; // channel decode, hit in the top bit

	// map an address onto a channel index; hit is the top bit
	function automatic logic [2:0] acs_chan(input logic [6:0] a);
		unique case (a)
			`ACS_ADDR_CH0: acs_chan = 3'h4;
			`ACS_ADDR_CH1: acs_chan = 3'h5;
			`ACS_ADDR_CH2: acs_chan = 3'h6;
			`ACS_ADDR_CH3: acs_chan = 3'h7;
			default: acs_chan = 3'h0;
		endcase
	endfunction : acs_chan

	// result of one channel for its selector setting
	function automatic logic [15:0] acs_sample(input logic [1:0] sel,
		input logic [15:0] raw);
		unique case (sel)
			`ACS_MUX_NORM: acs_sample = raw; // R1
			`ACS_MUX_SHORT: acs_sample = `ACS_ZERO16; // R1
			`ACS_MUX_POS: acs_sample = `ACS_TEST_POS; // R1
			`ACS_MUX_NEG: acs_sample = `ACS_TEST_NEG; // R1
		endcase
	endfunction : acs_sample

	// crc over all configuration words, channel 3 msb first
	function automatic logic [15:0] acs_crc(input logic [63:0] d);
		logic [15:0] r;
		logic fb;
		r = `ACS_CRC_INIT;
		fb = 1'b0;
		for (int i = 63; i >= 0; i--) begin
			fb = r[15] ^ d[i];
			r = {r[14:0], 1'b0};
			if (fb) begin
				r = r ^ `ACS_CRC_POLY;
			end
		end
		acs_crc = r;
	endfunction : acs_crc

	// next state: edges, conversions, sync check and the serial frame
	always_comb begin
		s_nxt = s_r;
		clk_rise = lnk.external_clock_input & ~s_r.external_clock_input_q;
		sync_fall = ~lnk.sync_n & s_r.sync_q;
		cs_fall = ~lnk.cs_n & s_r.cs_q;
		cs_rise = lnk.cs_n & ~s_r.cs_q;
		sclk_rise = ~lnk.cs_n & lnk.sclk & ~s_r.sclk_q;
		sclk_fall = ~lnk.cs_n & ~lnk.sclk & s_r.sclk_q;
		conv = 1'b0;
		cmd = s_r.in_sh[31:16];
		wdat = s_r.in_sh[15:0];
		addr = cmd[`ACS_CMD_AHI:`ACS_CMD_ALO];
		chan_hit = acs_chan(addr);
		s_nxt.external_clock_input_q = lnk.external_clock_input;
		s_nxt.sync_q = lnk.sync_n;
		s_nxt.cs_q = lnk.cs_n;
		s_nxt.sclk_q = lnk.sclk;
		// checksum tracks the map one cycle behind every write
		s_nxt.crc = acs_crc(s_r.cfg); // R2
		// frame start: snapshot status, answer and held results
		if (cs_fall) begin
			s_nxt.bits = 7'h00;
			s_nxt.out_sh = {s_r.resync, ~s_r.data_ready_pin_n, 14'h0000, s_r.resp,
				s_r.res[0], s_r.res[1], s_r.res[2], s_r.res[3]};
			s_nxt.dout = s_r.resync;
			s_nxt.dout_oe_n = 1'b0;
		end
		// sample din on sclk rise; only the first two words matter
		if (sclk_rise && s_r.bits != `ACS_FRAME_BITS) begin
			s_nxt.bits = s_r.bits + 7'h01;
			if (s_r.bits < `ACS_CMD_BITS) begin
				s_nxt.in_sh = {s_r.in_sh[30:0], lnk.din};
			end
		end
		// advance dout on sclk fall
		if (sclk_fall) begin
			s_nxt.dout = s_r.out_sh[94];
			s_nxt.out_sh = {s_r.out_sh[94:0], 1'b0};
		end
		// frame end: released bus; only a complete frame counts
		if (cs_rise) begin
			s_nxt.dout_oe_n = 1'b1; // R10
			if (s_r.bits == `ACS_FRAME_BITS) begin
				s_nxt.read_done = 1'b1; // R5
				s_nxt.data_ready_pin_n = 1'b1;
				s_nxt.resync = 1'b0; // status was delivered
				if (cmd[`ACS_CMD_WR] && chan_hit[2]) begin
					s_nxt.cfg[chan_hit[1:0]] = wdat;
				end
				// answer read back in the next frame
				if (chan_hit[2]) begin
					s_nxt.resp = s_r.cfg[chan_hit[1:0]] &
						`ACS_CFG_RMASK;
				end else if (addr == `ACS_ADDR_CRC) begin
					s_nxt.resp = s_r.crc; // R2
				end else begin
					s_nxt.resp = `ACS_ZERO16;
				end
			end
		end
		// conversion period counted on external_clock_input rises
		if (clk_rise) begin
			if (s_r.conv_cnt == `ACS_CONV_LAST) begin
				s_nxt.conv_cnt = 8'h00;
				conv = 1'b1;
			end else begin
				s_nxt.conv_cnt = s_r.conv_cnt + 8'h01;
			end
		end
		// sync is a check: aligned only at the period boundary edge
		if (sync_fall && !(clk_rise && s_r.conv_cnt == `ACS_CONV_LAST))
		begin
			s_nxt.conv_cnt = 8'h00; // R4
			s_nxt.resync = 1'b1; // R3
		end
		// unread results are kept so the same data go out again
		if (conv && s_nxt.read_done) begin
			for (int i = 0; i < 4; i++) begin
				s_nxt.res[i] = acs_sample(s_r.cfg[i][1:0], i_ain[i]);
			end
			s_nxt.read_done = 1'b0; // R5
			s_nxt.data_ready_pin_n = 1'b0;
		end
	end

	// state register
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			s_r <= '0;
			s_r.read_done <= 1'b1; // first conversion loads at once
			s_r.data_ready_pin_n <= 1'b1;
			s_r.dout_oe_n <= 1'b1; // R10
			s_r.cs_q <= 1'b1;
			s_r.sync_q <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	// outputs straight from the state register
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			o_chan_sel[i] = s_r.cfg[i][1:0]; // R1
		end
	end
	assign o_resync_flag = s_r.resync;
	assign lnk.dout = s_r.dout;
	assign lnk.dout_oe_n = s_r.dout_oe_n;
	assign lnk.data_ready_pin_n = s_r.data_ready_pin_n;
endmodule : acs_dev
`default_nettype wire

// ### verilog/acs_host.sv
// Purpose: host end: external_clock_input, aligned sync, full frames, interrupts
// Assumes: software port with read data one cycle after the strobe
// Notes: external_clock_input period counting gives a sample timebase
`timescale 1ns/1ns
`default_nettype none
`include "acs_cfg.svh"
module acs_host import acs_pkg::*; (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic [3:0] i_addr,
	input wire logic [15:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [15:0] o_rdata,
	output logic o_irq,
	acs_link_if.host lnk
);
	acs_host_st_t s_r; // registered state
	acs_host_st_t s_nxt; // next state
	logic tick; // sclk half period elapsed
	logic crise; // external_clock_input goes high this cycle
	logic [3:0] ev; // interrupt events
	logic [3:0] clr; // write-one-to-clear pattern

	// next state: dividers, sync, frame sequencer and register port
	always_comb begin
		s_nxt = s_r;
		ev = 4'h0;
		clr = 4'h0;
		crise = 1'b0;
		tick = (s_r.div == `ACS_SCLK_LAST);
		s_nxt.div = tick ? 4'h0 : s_r.div + 4'h1;
		s_nxt.rdata = 16'h0000;
		s_nxt.data_ready_pin_q = lnk.data_ready_pin_n;
		// external_clock_input generator; periods counted as the timebase
		if (s_r.cdiv == `ACS_EXTERNAL_CLOCK_INPUT_LAST) begin
			s_nxt.cdiv = 4'h0;
			s_nxt.external_clock_input = ~s_r.external_clock_input;
			crise = ~s_r.external_clock_input;
		end else begin
			s_nxt.cdiv = s_r.cdiv + 4'h1;
		end
		if (crise) begin
			if (s_r.pcnt == `ACS_CONV_LAST) begin
				s_nxt.pcnt = 8'h00; // R7
				s_nxt.periods = s_r.periods + 16'h0001;
				ev[`ACS_IRQ_PERIOD] = 1'b1;
			end else begin
				s_nxt.pcnt = s_r.pcnt + 8'h01;
			end
			// sync falls with external_clock_input at the period boundary only
			if (s_r.sync_req && s_r.pcnt == `ACS_CONV_LAST) begin
				s_nxt.sync_n = 1'b0; // R4
				s_nxt.sync_req = 1'b0;
			end else begin
				s_nxt.sync_n = 1'b1;
			end
		end
		// data ready watched so no sample is missed
		if (s_r.data_ready_pin_q && !lnk.data_ready_pin_n) begin
			ev[`ACS_IRQ_DATA_READY_PIN] = 1'b1; // R8
		end
		// register writes
		if (i_wr) begin
			unique case (i_addr)
				`ACS_H_CTRL: begin
					if (i_wdata[`ACS_CTRL_SYNC]) begin
						s_nxt.sync_req = 1'b1;
					end
				end
				`ACS_H_CMD: s_nxt.cmd = i_wdata;
				`ACS_H_WDAT: s_nxt.wdat = i_wdata;
				`ACS_H_IST: clr = i_wdata[3:0];
				`ACS_H_MASK: s_nxt.mask = i_wdata[3:0];
				default: ;
			endcase
		end
		// frame sequencer; a frame never stops short
		unique case (s_r.st)
			ACS_H_IDLE: begin
				if (i_wr && i_addr == `ACS_H_CTRL &&
					i_wdata[`ACS_CTRL_START]) begin
					s_nxt.tx = {s_r.cmd, s_r.wdat, 64'h0};
					s_nxt.din = s_r.cmd[15];
					s_nxt.cs_n = 1'b0; // R9
					s_nxt.bits = 7'h00;
					s_nxt.div = 4'h0;
					s_nxt.st = ACS_H_XFER;
				end
			end
			ACS_H_XFER: begin
				if (tick && !s_r.sclk) begin
					s_nxt.sclk = 1'b1;
					s_nxt.rx = {s_r.rx[94:0], lnk.dout_line};
					s_nxt.bits = s_r.bits + 7'h01;
				end else if (tick) begin
					s_nxt.sclk = 1'b0;
					if (s_r.bits == `ACS_FRAME_BITS) begin
						s_nxt.cs_n = 1'b1; // R6
						s_nxt.din = 1'b0;
						s_nxt.rx_hold = s_r.rx;
						s_nxt.st = ACS_H_IDLE;
						ev[`ACS_IRQ_DONE] = 1'b1;
						ev[`ACS_IRQ_RESYNC] =
							s_r.rx[`ACS_STAT_LSB + `ACS_ST_RESYNC];
					end else begin
						s_nxt.din = s_r.tx[94];
						s_nxt.tx = {s_r.tx[94:0], 1'b0};
					end
				end
			end
		endcase
		// register reads, answer in the next cycle only
		if (i_rd) begin
			unique case (i_addr)
				`ACS_H_CTRL: s_nxt.rdata = {14'h0000, s_r.sync_req,
					s_r.st == ACS_H_XFER};
				`ACS_H_CMD: s_nxt.rdata = s_r.cmd;
				`ACS_H_WDAT: s_nxt.rdata = s_r.wdat;
				`ACS_H_STAT: s_nxt.rdata = s_r.rx_hold[95:80];
				`ACS_H_RESP: s_nxt.rdata = s_r.rx_hold[79:64];
				`ACS_H_CH0: s_nxt.rdata = s_r.rx_hold[63:48];
				`ACS_H_CH1: s_nxt.rdata = s_r.rx_hold[47:32];
				`ACS_H_CH2: s_nxt.rdata = s_r.rx_hold[31:16];
				`ACS_H_CH3: s_nxt.rdata = s_r.rx_hold[15:0];
				`ACS_H_IST: s_nxt.rdata = {12'h000, s_r.ist};
				`ACS_H_MASK: s_nxt.rdata = {12'h000, s_r.mask};
				`ACS_H_PER: s_nxt.rdata = s_r.periods;
				default: s_nxt.rdata = 16'h0000;
			endcase
		end
		// sticky status: a new event wins over its clear
		s_nxt.ist = (s_r.ist & ~clr) | ev;
		s_nxt.irq = |(s_nxt.ist & s_nxt.mask);
	end

	// state register
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			s_r <= '0;
			s_r.st <= ACS_H_IDLE;
			s_r.cs_n <= 1'b1;
			s_r.sync_n <= 1'b1;
			s_r.data_ready_pin_q <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	// outputs straight from the state register
	assign o_rdata = s_r.rdata;
	assign o_irq = s_r.irq;
	assign lnk.external_clock_input = s_r.external_clock_input;
	assign lnk.sync_n = s_r.sync_n;
	assign lnk.cs_n = s_r.cs_n;
	assign lnk.sclk = s_r.sclk;
	assign lnk.din = s_r.din;
endmodule : acs_host
`default_nettype wire

// ### bench/acs_checker.sv
// Purpose: watches the serial link joining the host and converter ends
// Assumes: one system clock; every link signal but dout_line is registered
// Notes: sclk rises per frame are counted here, since the link has no count
`timescale 1ns/1ns
`default_nettype none
module acs_checker (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic external_clock_input,
	input wire logic sync_n,
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic din,
	input wire logic dout,
	input wire logic dout_oe_n,
	input wire logic data_ready_pin_n,
	input wire logic dout_line
);
	logic [6:0] rises_r; // sclk rises seen while selected
	// count rises; cleared while deselected so each frame starts at zero
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			rises_r <= 7'h00;
		end else if (cs_n) begin
			rises_r <= 7'h00;
		end else if ($rose(sclk)) begin
			rises_r <= rises_r + 7'h01;
		end
	end
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_reset);
	// two cycles of slack cover the registered chip-select sample
	chk_dout_release: assert property (cs_n && $past(cs_n, 2) |-> dout_oe_n)
		else $error("data out driven while deselected");
	chk_first_bit: assert property ($fell(cs_n) |-> ##2 !dout_oe_n)
		else $error("data out not driven two cycles after select");
	chk_sclk_idle: assert property (cs_n |-> !sclk)
		else $error("serial clock moves outside a frame");
	chk_sclk_half: assert property ($rose(sclk) |=> sclk[*3] ##1 !sclk)
		else $error("serial clock high phase not four cycles");
	chk_frame_len: assert property ($rose(cs_n) |-> rises_r == 7'h60)
		else $error("frame ended without all words clocked");
	chk_external_clock_input_step: assert property ($rose(external_clock_input) |=> external_clock_input ##1 !external_clock_input)
		else $error("conversion clock high phase not two cycles");
	chk_sync_width: assert property ($fell(sync_n) |=> !sync_n[*3] ##1 sync_n)
		else $error("sync pulse not one external_clock_input period wide");
	chk_sync_edge: assert property ($fell(sync_n) |-> $rose(external_clock_input))
		else $error("sync pulse not in step with external_clock_input");
	chk_data_ready_pin_frame: assert property ($rose(data_ready_pin_n) |-> ##[0:4] cs_n)
		else $error("data ready released without a whole frame");
	// host data may only move while the serial clock is low
	chk_din_stable: assert property (sclk |-> $stable(din))
		else $error("host data changed while serial clock high");
	// device data advance only after a falling serial clock edge
	chk_dout_stable: assert property (sclk |-> $stable(dout))
		else $error("device data changed while serial clock high");
	cov_frame: cover property ($rose(cs_n));
	cov_line: cover property (!cs_n && dout_line);
	cov_sync: cover property ($fell(sync_n));
	cov_data_ready_pin: cover property ($fell(data_ready_pin_n));
endmodule : acs_checker
`default_nettype wire

// ### bench/testbench.sv
// Purpose: self-checking bench joining host and converter ends
// Assumes: host map and frame order as handed over by the designer
// Notes: a small model holds the channel words and the map checksum
`timescale 1ns/1ns
`default_nettype none
`include "acs_cfg.svh"
module testbench;
	logic i_clk; // 20 MHz system clock
	logic i_reset; // async, active high
	logic [3:0] i_addr; // software port
	logic [15:0] i_wdata;
	logic i_wr;
	logic i_rd;
	logic [15:0] o_rdata;
	logic o_irq;
	logic [3:0][15:0] i_ain; // converter inputs, random
	logic [3:0][1:0] o_chan_sel;
	logic o_resync_flag;
	int fail_count; // mismatches
	int check_count; // comparisons
	int r; // random selector offset
	logic [15:0] m_cfg[4]; // model of the channel words
	logic [15:0] rd_v; // last value read
	logic [6:0] ch_addr[4]; // device offsets per channel
	logic [15:0] per_v; // first period count read
	logic host_rst; // host-only reset, moves its period phase
	logic h_reset; // reset of the host end and the checker
	assign h_reset = i_reset | host_rst;
	acs_link_if lnk_i ();
	acs_dev acs_dev_i (.i_clk(i_clk), .i_reset(i_reset), .i_ain(i_ain),
		.o_chan_sel(o_chan_sel), .o_resync_flag(o_resync_flag), .lnk(lnk_i));
	acs_host acs_host_i (.i_clk(i_clk), .i_reset(h_reset), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.o_irq(o_irq), .lnk(lnk_i));
	acs_checker acs_checker_i (.i_clk(i_clk), .i_reset(h_reset),
		.external_clock_input(lnk_i.external_clock_input), .sync_n(lnk_i.sync_n), .cs_n(lnk_i.cs_n),
		.sclk(lnk_i.sclk), .din(lnk_i.din), .dout(lnk_i.dout),
		.dout_oe_n(lnk_i.dout_oe_n), .data_ready_pin_n(lnk_i.data_ready_pin_n),
		.dout_line(lnk_i.dout_line));
	// free-running clock
	always #25 i_clk = ~i_clk;
	// one comparison; a mismatch is reported at once
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : check
	// counts, verdict and end of run
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : tally_and_finish
	// one-cycle write strobe
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge i_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask : wr
	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [3:0] a);
		@(posedge i_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1;
		rd_v = o_rdata;
	endtask : rd
	// poll a control bit until it drops; bounded so a hang ends the run
	task automatic wait_low(input int b);
		int n = 0;
		rd(`ACS_H_CTRL);
		while (rd_v[b] !== 1'b0) begin
			n++;
			if (n > 2000) begin
				fail_count++;
				tally_and_finish();
			end
			rd(`ACS_H_CTRL);
		end
	endtask : wait_low
	// a whole frame: command, write data, start, wait for idle
	task automatic frame(input logic [15:0] cmd, input logic [15:0] wd);
		wr(`ACS_H_CMD, cmd);
		wr(`ACS_H_WDAT, wd);
		wr(`ACS_H_CTRL, 16'h0001);
		wait_low(`ACS_CTRL_START);
	endtask : frame
	// reset the host a few external_clock_input rises into a period, then ask for sync;
	// the host's aligned pulse now misses the converter's period
	task automatic misalign_sync();
		int n = 0;
		wr(`ACS_H_IST, 16'h0008);
		rd(`ACS_H_IST);
		while (rd_v[`ACS_IRQ_PERIOD] !== 1'b1) begin
			n++;
			if (n > 200) begin
				fail_count++;
				tally_and_finish();
			end
			rd(`ACS_H_IST);
		end
		repeat (8) @(posedge i_clk);
		host_rst <= 1'b1;
		repeat (4) @(posedge i_clk);
		host_rst <= 1'b0;
		wr(`ACS_H_CTRL, 16'h0002);
		wait_low(`ACS_CTRL_SYNC);
		repeat (8) @(posedge i_clk);
	endtask : misalign_sync
	// map checksum over channel words 3 down to 0, msb first
	function automatic logic [15:0] crc_model();
		logic [15:0] c;
		c = `ACS_CRC_INIT;
		for (int w = 3; w >= 0; w--) begin
			for (int b = 15; b >= 0; b--) begin
				if (c[15] ^ m_cfg[w][b]) c = {c[14:0], 1'b0} ^ `ACS_CRC_POLY;
				else c = {c[14:0], 1'b0};
			end
		end
		return c;
	endfunction : crc_model
	// converted value for the selected input
	function automatic logic [15:0] exp_data(input int ch);
		case (m_cfg[ch][1:0])
			`ACS_MUX_NORM: return i_ain[ch];
			`ACS_MUX_SHORT: return `ACS_ZERO16;
			`ACS_MUX_POS: return `ACS_TEST_POS;
			default: return `ACS_TEST_NEG;
		endcase
	endfunction : exp_data
	// main sequence
	initial begin
		i_clk = 1'b0;
		i_reset = 1'b1;
		i_addr = 4'h0;
		i_wdata = 16'h0000;
		i_wr = 1'b0;
		i_rd = 1'b0;
		fail_count = 0;
		check_count = 0;
		host_rst = 1'b0;
		m_cfg = '{default: 16'h0000};
		ch_addr = '{`ACS_ADDR_CH0, `ACS_ADDR_CH1, `ACS_ADDR_CH2, `ACS_ADDR_CH3};
		r = $urandom(65149) % 4;
		i_ain = {$urandom, $urandom};
		repeat (4) @(posedge i_clk);
		i_reset <= 1'b0;
		// reset state, unmapped read, checksum reset value
		check({8'h00, o_chan_sel}, 16'h0000);
		check({15'h0000, o_resync_flag}, 16'h0000);
		check({15'h0000, lnk_i.dout_oe_n}, 16'h0001);
		rd(4'hC);
		check(rd_v, 16'h0000);
		frame({1'b0, `ACS_ADDR_CRC, 8'h00}, 16'h0000);
		frame({1'b0, `ACS_ADDR_CRC, 8'h00}, 16'h0000);
		rd(`ACS_H_RESP);
		check(rd_v, crc_model());
		$display("reset test done");
		// every selector code on some channel, done interrupt unmasked
		wr(`ACS_H_MASK, 16'h0001);
		for (int c = 0; c < 4; c++) begin
			m_cfg[c] = (16'($urandom) & 16'hFFFC) | 16'((c + r) % 4);
			frame({1'b1, ch_addr[c], 8'h00}, m_cfg[c]);
			repeat (2) @(posedge i_clk);
			check({14'h0000, o_chan_sel[c]}, {14'h0000, m_cfg[c][1:0]});
		end
		check({15'h0000, o_irq}, 16'h0001);
		wr(`ACS_H_IST, 16'h000F);
		rd(`ACS_H_IST);
		check({15'h0000, rd_v[`ACS_IRQ_DONE]}, 16'h0000);
		check({15'h0000, o_irq}, 16'h0000);
		$display("selector test done");
		// masked done; readback and checksum arrive one frame late
		wr(`ACS_H_MASK, 16'h0000);
		frame({1'b0, `ACS_ADDR_CH2, 8'h00}, 16'h0000);
		frame({1'b0, `ACS_ADDR_CRC, 8'h00}, 16'h0000);
		rd(`ACS_H_RESP);
		check(rd_v, m_cfg[2] & `ACS_CFG_RMASK);
		frame({1'b0, `ACS_ADDR_CRC, 8'h00}, 16'h0000);
		rd(`ACS_H_RESP);
		check(rd_v, crc_model());
		check({15'h0000, o_irq}, 16'h0000);
		rd(`ACS_H_IST);
		check({15'h0000, rd_v[`ACS_IRQ_DONE]}, 16'h0001);
		check({15'h0000, rd_v[`ACS_IRQ_DATA_READY_PIN]}, 16'h0001);
		// results now follow the final selectors
		for (int c = 0; c < 4; c++) begin
			rd(4'(`ACS_H_CH0 + c));
			check(rd_v, exp_data(c));
		end
		$display("checksum and data test done");
		// aligned sync request, then an idle released line
		wr(`ACS_H_CTRL, 16'h0002);
		wait_low(`ACS_CTRL_SYNC);
		repeat (8) @(posedge i_clk);
		check({15'h0000, o_resync_flag}, 16'h0000);
		check({15'h0000, lnk_i.dout_oe_n}, 16'h0001);
		// strobes 128 cycles apart span exactly two conversion periods
		rd(`ACS_H_PER);
		per_v = rd_v;
		repeat (126) @(posedge i_clk);
		rd(`ACS_H_PER);
		check(rd_v - per_v, 16'h0002);
		$display("sync test done");
		// misaligned sync sets the flag; a full frame clears it; again
		misalign_sync();
		check({15'h0000, o_resync_flag}, 16'h0001);
		frame({1'b0, `ACS_ADDR_CRC, 8'h00}, 16'h0000);
		rd(`ACS_H_IST);
		check({15'h0000, rd_v[`ACS_IRQ_RESYNC]}, 16'h0001);
		check({15'h0000, o_resync_flag}, 16'h0000);
		misalign_sync();
		check({15'h0000, o_resync_flag}, 16'h0001);
		$display("resync test done");
		tally_and_finish();
	end
endmodule : testbench
`default_nettype wire
